// file: common/ebac_pkg.sv
/*
 Package for the byte EEPROM access control: register offsets, control
 field positions, mode codes and programming times.
 Assumes a 50 MHz system clock, divided by EBAC_OSC_DIV (6) to give a one-in-six tick, 8.33 MHz, standing for the 8 MHz oscillator.
*/
package ebac_pkg;
   localparam int          EBAC_AW            = 8;
   localparam int          EBAC_DEPTH         = 256;
   localparam logic [1:0]  EBAC_OFS_CTRL      = 2'h0;
   localparam logic [1:0]  EBAC_OFS_ADDR      = 2'h1;
   localparam logic [1:0]  EBAC_OFS_DATA      = 2'h2;
   localparam int          EBAC_BIT_READ      = 0;
   localparam int          EBAC_BIT_START     = 1;
   localparam int          EBAC_BIT_ARM       = 2;
   localparam int          EBAC_BIT_RIE       = 3;
   localparam int          EBAC_BIT_PM_LO     = 4;
   localparam int          EBAC_BIT_PM_HI     = 5;
   localparam logic [1:0]  EBAC_PM_RESET      = 2'h0;
   localparam logic [7:0]  EBAC_ERASED        = 8'hff;
   localparam int          EBAC_ARM_CYC       = 4;
   localparam int          EBAC_READ_HALT     = 4;
   localparam int          EBAC_PROG_HALT     = 2;
   localparam int          EBAC_OSC_KHZ       = 8000;
   localparam int          EBAC_ATOMIC_US     = 3400;
   localparam int          EBAC_SPLIT_US      = 1800;
   localparam int          EBAC_ATOMIC_TICKS  = EBAC_ATOMIC_US * EBAC_OSC_KHZ / 1000;
   localparam int          EBAC_SPLIT_TICKS   = EBAC_SPLIT_US * EBAC_OSC_KHZ / 1000;
   localparam int          EBAC_OSC_DIV       = 50000 / EBAC_OSC_KHZ;
   typedef enum logic [1:0] {
      EBAC_PM_ATOMIC = 2'b00,
      EBAC_PM_ERASE  = 2'b01,
      EBAC_PM_WRITE  = 2'b10,
      EBAC_PM_RSVD   = 2'b11
   } ebac_pm_t;
endpackage : ebac_pkg

// file: common/ebac_if.sv
/*
 Register port between the CPU end and the EEPROM control end.
 Assumes both ends share ref_clk.
*/
`timescale 1ns/10ps
interface ebac_if;
   logic       wr_en;
   logic       rd_en;
   logic [1:0] addr;
   logic [7:0] wdata;
   logic [7:0] rdata;
   logic       halt;
   logic       irq;
   modport device (input wr_en, rd_en, addr, wdata, output rdata, halt, irq);
   modport cpu    (output wr_en, rd_en, addr, wdata, input rdata, halt, irq);
endinterface : ebac_if

// file: hdl/ebac_cpu.sv
/*
 CPU-side sequencer: runs read, atomic/erase/write programming sequences.
 Assumes the device end on the same clock; user gives one command pulse.
*/
`timescale 1ns/10ps
module ebac_cpu
   import ebac_pkg::*;
(
   input  wire logic       ref_clk,
   input  wire logic       rst,
   input  wire logic       cmd_valid,
   input  wire logic       cmd_prog,
   input  wire logic [1:0] cmd_mode,
   input  wire logic [7:0] cmd_addr,
   input  wire logic [7:0] cmd_data,
   output logic            cmd_ready,
   output logic            rsp_valid,
   output logic [7:0]      rsp_data,
   ebac_if.cpu             bus
);
   typedef enum logic [3:0] {
      C_IDLE = 4'h0, C_POLL = 4'h1, C_PCHK = 4'h2, C_MODE = 4'h3, C_ADDR = 4'h4,
      C_DATA = 4'h5, C_ARM = 4'h6, C_GO = 4'h7, C_RD = 4'h8, C_FETCH = 4'h9,
      C_CATCH = 4'ha, C_PWAIT = 4'hb
   } ebac_cst_t;
   typedef struct packed {
      ebac_cst_t  st;
      logic       prog;
      logic [1:0] mode;
      logic [7:0] addr;
      logic [7:0] data;
      logic       wr;
      logic       rd;
      logic [1:0] ra;
      logic [7:0] wd;
      logic       rdy;
      logic       rv;
      logic [7:0] rsp;
   } ebac_cs_t;
   ebac_cs_t s_q, s_d;

   always_comb begin
      s_d    = s_q;
      s_d.wr = 1'b0;
      s_d.rd = 1'b0;
      s_d.rv = 1'b0;
      if (!bus.halt) begin
         case (s_q.st)
            C_IDLE: begin
               if (cmd_valid) begin
                  s_d.prog = cmd_prog;
                  s_d.mode = cmd_mode;
                  s_d.addr = cmd_addr;
                  s_d.data = cmd_data;
                  s_d.rdy  = 1'b0;
                  s_d.st   = C_POLL;
               end
            end
            C_POLL: begin
               s_d.rd = 1'b1;
               s_d.ra = EBAC_OFS_CTRL;
               s_d.st = C_PWAIT;
            end
            C_PWAIT: begin
               s_d.st = C_PCHK;
            end
            C_PCHK: begin
               if (bus.rdata[EBAC_BIT_START]) s_d.st = C_POLL;
               else if (s_q.prog) s_d.st = C_MODE;
               else s_d.st = C_ADDR;
            end
            C_MODE: begin
               s_d.wr = 1'b1;
               s_d.ra = EBAC_OFS_CTRL;
               s_d.wd = 8'h00;
               s_d.wd[EBAC_BIT_PM_HI] = s_q.mode[1];
               s_d.wd[EBAC_BIT_PM_LO] = s_q.mode[0];
               s_d.wd[EBAC_BIT_RIE] = 1'b1;
               s_d.st = C_ADDR;
            end
            C_ADDR: begin
               s_d.wr = 1'b1;
               s_d.ra = EBAC_OFS_ADDR;
               s_d.wd = s_q.addr;
               s_d.st = s_q.prog ? C_DATA : C_RD;
            end
            C_DATA: begin
               s_d.wr = 1'b1;
               s_d.ra = EBAC_OFS_DATA;
               s_d.wd = s_q.data;
               s_d.st = C_ARM;
            end
            C_ARM: begin
               s_d.wr = 1'b1;
               s_d.ra = EBAC_OFS_CTRL;
               s_d.wd = 8'h00;
               s_d.wd[EBAC_BIT_ARM] = 1'b1;
               s_d.wd[EBAC_BIT_RIE] = 1'b1;
               s_d.wd[EBAC_BIT_PM_HI] = s_q.mode[1];
               s_d.wd[EBAC_BIT_PM_LO] = s_q.mode[0];
               s_d.st = C_GO;
            end
            C_GO: begin
               s_d.wr = 1'b1;
               s_d.ra = EBAC_OFS_CTRL;
               s_d.wd = 8'h00;
               s_d.wd[EBAC_BIT_ARM] = 1'b1;
               s_d.wd[EBAC_BIT_START] = 1'b1;
               s_d.wd[EBAC_BIT_RIE] = 1'b1;
               s_d.wd[EBAC_BIT_PM_HI] = s_q.mode[1];
               s_d.wd[EBAC_BIT_PM_LO] = s_q.mode[0];
               s_d.rdy = 1'b1;
               s_d.st = C_IDLE;
            end
            C_RD: begin
               s_d.wr = 1'b1;
               s_d.ra = EBAC_OFS_CTRL;
               s_d.wd = 8'h00;
               s_d.wd[EBAC_BIT_READ] = 1'b1;
               s_d.wd[EBAC_BIT_RIE] = 1'b1;
               s_d.st = C_FETCH;
            end
            C_FETCH: begin
               s_d.rd = 1'b1;
               s_d.ra = EBAC_OFS_DATA;
               s_d.st = C_CATCH;
            end
            C_CATCH: begin
               s_d.rsp = bus.rdata;
               s_d.rv  = 1'b1;
               s_d.rdy = 1'b1;
               s_d.st  = C_IDLE;
            end
            default: s_d.st = C_IDLE;
         endcase
      end
   end

   always_ff @(posedge ref_clk) begin
      if (rst) begin
         s_q     <= '0;
         s_q.st  <= C_IDLE;
         s_q.rdy <= 1'b1;
      end else begin
         s_q <= s_d;
      end
   end

   assign bus.wr_en = s_q.wr;
   assign bus.rd_en = s_q.rd;
   assign bus.addr  = s_q.ra;
   assign bus.wdata = s_q.wd;
   assign cmd_ready = s_q.rdy;
   assign rsp_valid = s_q.rv;
   assign rsp_data  = s_q.rsp;
endmodule : ebac_cpu

// file: hdl/ebac_nvm.sv
/*
 EEPROM byte access control: control, address and data registers, read,
 atomic/erase/write programming timed by an 8 MHz tick, CPU halt, ready irq.
 Assumes register accesses from the CPU end on ref_clk.
*/
`timescale 1ns/10ps
// Behaviour
// - 256 bytes, each read and programmed singly
// - Programming timed from 8 MHz oscillator
// - Atomic mode erases then writes byte
// - Erase and write may run separately
// - Mode bits pick atomic, erase, write
// - 00 atomic 3.4ms, 01/10 1.8ms, 11 reserved
// - Completion shown by start flag or irq
// - Ready irq gated by its enable
// - CPU polls start flag before operations
// - Read strobe reads byte, halts four cycles
// - Read byte held in data register
// - CPU arms then starts within four cycles
// - Arm self-clears after four; unarmed start ignored
// - Programming start halts CPU two cycles
// - Start flag stays set until done
// - Busy refuses reads and address changes
// - Mode bits locked while start flag set
// - Reset clears mode unless programming
// - CPU erases before write-only use
// - CPU sets mode, address, data first
// - Reset does not abort running programming
module ebac_nvm
   import ebac_pkg::*;
#(
   parameter int ATOMIC_TICKS = EBAC_ATOMIC_TICKS,
   parameter int SPLIT_TICKS  = EBAC_SPLIT_TICKS
)(
   input  wire logic ref_clk,
   input  wire logic rst,
   ebac_if.device    bus
);
   typedef struct packed {
      logic [7:0]  addr;
      logic [7:0]  data;
      logic [1:0]  pm;
      logic        rie;
      logic        arm;
      logic [2:0]  arm_cnt;
      logic        busy;
      ebac_pm_t    op;
      logic [7:0]  op_addr;
      logic [7:0]  op_data;
      logic [15:0] tcnt;
      logic [2:0]  div;
      logic [2:0]  halt_cnt;
      logic        halt;
      logic [7:0]  rdata;
      logic        irq;
   } ebac_ns_t;

   ebac_ns_t   s_q;
   ebac_ns_t   s_d;
   logic [7:0] mem_q [EBAC_DEPTH];
   logic       tick;
   logic       done;
   logic       start_ok;
   logic       read_ok;

   // Programming time for a mode
   function automatic logic [15:0] dur(input ebac_pm_t m);
      if (m == EBAC_PM_ATOMIC) begin
         dur = 16'(ATOMIC_TICKS);
      end else begin
         dur = 16'(SPLIT_TICKS);
      end
   endfunction : dur

   // Control register image
   function automatic logic [7:0] ctrl_image(input ebac_ns_t s);
      ctrl_image                 = 8'h00;
      ctrl_image[EBAC_BIT_START] = s.busy;
      ctrl_image[EBAC_BIT_ARM]   = s.arm;
      ctrl_image[EBAC_BIT_RIE]   = s.rie;
      ctrl_image[EBAC_BIT_PM_LO] = s.pm[0];
      ctrl_image[EBAC_BIT_PM_HI] = s.pm[1];
   endfunction : ctrl_image

   assign tick     = (s_q.div == 3'(EBAC_OSC_DIV - 1));
   assign done     = s_q.busy && tick && (s_q.tcnt == 16'h0001);
   assign start_ok = s_q.arm && !s_q.busy && (s_q.pm != EBAC_PM_RSVD);
   assign read_ok  = !s_q.busy;

   always_comb begin
      s_d = s_q;
      if (tick) begin
         s_d.div = 3'h0;
      end else begin
         s_d.div = s_q.div + 3'h1;
      end
      if (s_q.halt_cnt != 3'h0) begin
         s_d.halt_cnt = s_q.halt_cnt - 3'h1;
      end
      if (s_q.arm) begin
         if (s_q.arm_cnt == 3'(EBAC_ARM_CYC - 1)) begin
            s_d.arm = 1'b0;
         end else begin
            s_d.arm_cnt = s_q.arm_cnt + 3'h1;
         end
      end

      // Tick counter and busy
      if (s_q.busy && tick) begin
         s_d.tcnt = s_q.tcnt - 16'h0001;
      end
      if (done) begin
         s_d.busy = 1'b0;
      end

      // Register reads
      if (bus.rd_en) begin
         if (bus.addr == EBAC_OFS_CTRL) begin
            s_d.rdata = ctrl_image(s_q);
         end else if (bus.addr == EBAC_OFS_ADDR) begin
            s_d.rdata = s_q.addr;
         end else if (bus.addr == EBAC_OFS_DATA) begin
            s_d.rdata = s_q.data;
         end else begin
            s_d.rdata = 8'h00;
         end
      end

      // Register writes, ignored while halted
      if (bus.wr_en && !s_q.halt) begin
         if (bus.addr == EBAC_OFS_CTRL) begin
            s_d.rie = bus.wdata[EBAC_BIT_RIE];
            if (!s_q.busy) begin
               s_d.pm = bus.wdata[EBAC_BIT_PM_HI:EBAC_BIT_PM_LO];
            end
            if (bus.wdata[EBAC_BIT_ARM] && !s_q.arm && !s_q.busy) begin
               s_d.arm     = 1'b1;
               s_d.arm_cnt = 3'h0;
            end
            if (bus.wdata[EBAC_BIT_START] && start_ok) begin
               s_d.busy     = 1'b1;
               s_d.arm      = 1'b0;
               s_d.op       = ebac_pm_t'(s_q.pm);
               s_d.op_addr  = s_q.addr;
               s_d.op_data  = s_q.data;
               s_d.tcnt     = dur(ebac_pm_t'(s_q.pm));
               s_d.halt_cnt = 3'(EBAC_PROG_HALT);
            end else if (bus.wdata[EBAC_BIT_READ] && read_ok) begin
               s_d.data     = mem_q[s_q.addr];
               s_d.halt_cnt = 3'(EBAC_READ_HALT);
            end
         end else if (bus.addr == EBAC_OFS_ADDR) begin
            if (read_ok) begin
               s_d.addr = bus.wdata;
            end
         end else if (bus.addr == EBAC_OFS_DATA) begin
            s_d.data = bus.wdata;
         end
      end

      s_d.halt = (s_d.halt_cnt != 3'h0);
      s_d.irq  = s_d.rie && !s_d.busy;
   end

   always_ff @(posedge ref_clk) begin
      if (rst) begin
         s_q.addr     <= 8'h00;
         s_q.data     <= 8'h00;
         s_q.rie      <= 1'b0;
         s_q.arm      <= 1'b0;
         s_q.arm_cnt  <= 3'h0;
         s_q.halt_cnt <= 3'h0;
         s_q.halt     <= 1'b0;
         s_q.rdata    <= 8'h00;
         s_q.irq      <= 1'b0;

         s_q.div      <= s_d.div;
         s_q.busy     <= s_d.busy;
         s_q.op       <= s_d.op;
         s_q.op_addr  <= s_d.op_addr;
         s_q.op_data  <= s_d.op_data;
         s_q.tcnt     <= s_d.tcnt;
         if (s_d.busy) begin
            s_q.pm <= s_d.pm;
         end else begin
            s_q.pm <= EBAC_PM_RESET;
         end
      end else begin
         s_q <= s_d;
      end
   end

   always_ff @(posedge ref_clk) begin
      if (done) begin
         if (s_q.op == EBAC_PM_ATOMIC) begin
            mem_q[s_q.op_addr] <= s_q.op_data;
         end else if (s_q.op == EBAC_PM_ERASE) begin
            mem_q[s_q.op_addr] <= EBAC_ERASED;
         end else begin
            mem_q[s_q.op_addr] <= mem_q[s_q.op_addr] & s_q.op_data;
         end
      end
   end

   assign bus.rdata = s_q.rdata;
   assign bus.halt  = s_q.halt;
   assign bus.irq   = s_q.irq;
endmodule : ebac_nvm

// file: bench/ebac_nvm_asserts.sv
/*
 Checker on the register port between the CPU end and the EEPROM end.
 Assumes the CPU end polls busy first and never starts with mode 11.
*/
`timescale 1ns/10ps
module ebac_nvm_asserts
   import ebac_pkg::*;
#(
   parameter int ATOMIC_TICKS = EBAC_ATOMIC_TICKS
)(
   input wire logic       ref_clk,
   input wire logic       rst,
   input wire logic       wr_en,
   input wire logic       rd_en,
   input wire logic [1:0] addr,
   input wire logic [7:0] wdata,
   input wire logic [7:0] rdata,
   input wire logic       halt,
   input wire logic       irq
);
   localparam int BUSY_MAX = ATOMIC_TICKS * EBAC_OSC_DIV + 12;
   logic        ctrl_wr;
   logic        ctrl_rd;
   logic [15:0] arm_age_q   = 16'hffff;
   logic [15:0] start_age_q = 16'hffff;
   assign ctrl_wr = wr_en && !halt && addr == EBAC_OFS_CTRL;
   assign ctrl_rd = rd_en && !halt && addr == EBAC_OFS_CTRL;
   // Ages survive reset, as a running operation does
   always_ff @(posedge ref_clk) begin
      arm_age_q   <= (ctrl_wr && wdata[EBAC_BIT_ARM]) ? 16'h0 :
                     (arm_age_q == 16'hffff) ? arm_age_q : arm_age_q + 16'h1;
      start_age_q <= (ctrl_wr && wdata[EBAC_BIT_START]) ? 16'h0 :
                     (start_age_q == 16'hffff) ? start_age_q : start_age_q + 16'h1;
   end
   default clocking @(posedge ref_clk); endclocking
   default disable iff (rst);
   a_read_halt_four: assert property (ctrl_wr && wdata[EBAC_BIT_READ] |=> halt[*4] ##1 !halt)
      else $error("read halt not four cycles");
   a_prog_halt_two: assert property (ctrl_wr && wdata[EBAC_BIT_START] |=> halt[*2] ##1 !halt)
      else $error("programming halt not two cycles");
   a_arm_no_halt: assert property (ctrl_wr && wdata[EBAC_BIT_ARM] && !wdata[EBAC_BIT_START]
                                   && !wdata[EBAC_BIT_READ] |=> !halt)
      else $error("arm write alone halted");
   a_busy_shown: assert property (ctrl_rd && start_age_q < 16'd30 |=> rdata[EBAC_BIT_START])
      else $error("busy flag low during programming");
   a_busy_ends: assert property (ctrl_rd && start_age_q > BUSY_MAX |=> !rdata[EBAC_BIT_START])
      else $error("busy flag stuck after programming");
   a_arm_self_clear: assert property (ctrl_rd && arm_age_q >= 16'd6 |=> !rdata[EBAC_BIT_ARM])
      else $error("arm bit did not clear");
   a_rdata_holds: assert property (!rd_en |=> $stable(rdata))
      else $error("read data changed without a read");
   a_irq_low_busy: assert property (ctrl_wr && wdata[EBAC_BIT_START] |=> !irq[*2])
      else $error("ready irq high while busy");
   a_ctrl_zero_bits: assert property (ctrl_rd |=> rdata[7:6] == 2'h0 && !rdata[EBAC_BIT_READ])
      else $error("control read shows set constant bits");
endmodule : ebac_nvm_asserts

// file: bench/eeprom_byte_access_control_test.sv
/*
 Testbench: CPU end and EEPROM end joined by the register interface.
 Assumes short programming counts and the CPU end polling busy itself.
*/
`timescale 1ns/10ps
module eeprom_byte_access_control_test
   import ebac_pkg::*;
;
   localparam int AT = 20;
   localparam int ST = 10;
   logic       ref_clk   = 1'b0;
   logic       rst       = 1'b1;
   logic       cmd_valid = 1'b0;
   logic       cmd_prog  = 1'b0;
   logic [1:0] cmd_mode  = 2'h0;
   logic [7:0] cmd_addr  = 8'h00;
   logic [7:0] cmd_data  = 8'h00;
   logic       cmd_ready;
   logic       rsp_valid;
   logic [7:0] rsp_data;
   int         fails     = 0;
   int         tests_run = 0;
   int         cycles    = 0;
   ebac_if bus_if ();
   ebac_cpu i_ebac_cpu (.ref_clk(ref_clk), .rst(rst), .cmd_valid(cmd_valid),
      .cmd_prog(cmd_prog), .cmd_mode(cmd_mode), .cmd_addr(cmd_addr), .cmd_data(cmd_data),
      .cmd_ready(cmd_ready), .rsp_valid(rsp_valid), .rsp_data(rsp_data), .bus(bus_if.cpu));
   ebac_nvm #(.ATOMIC_TICKS(AT), .SPLIT_TICKS(ST)) i_ebac_nvm (.ref_clk(ref_clk), .rst(rst),
      .bus(bus_if.device));
   ebac_nvm_asserts #(.ATOMIC_TICKS(AT)) i_ebac_nvm_asserts (.ref_clk(ref_clk), .rst(rst),
      .wr_en(bus_if.wr_en), .rd_en(bus_if.rd_en), .addr(bus_if.addr), .wdata(bus_if.wdata),
      .rdata(bus_if.rdata), .halt(bus_if.halt), .irq(bus_if.irq));
   always #10 ref_clk = ~ref_clk;
   always @(posedge ref_clk) begin
      cycles <= cycles + 1;
      if (cycles == 20000) begin
         fails++;
         complete_run();
      end
   end
   task automatic complete_run();
      $display("Checks %0d, mismatches %0d", tests_run, fails);
      if (fails == 0 && tests_run > 0) begin
         $display("Simulation passed");
      end else begin
         $display("Simulation failed");
      end
      $finish;
   endtask : complete_run
   task automatic check(input logic [7:0] got, input logic [7:0] exp, input string what);
      tests_run++;
      if (got !== exp) begin
         fails++;
         $display("CHECK FAILED at %0t: %s got %h want %h", $time, what, got, exp);
      end
   endtask : check
   // One command, held until the CPU end takes it
   task automatic send(input logic prog, input logic [1:0] mode, input logic [7:0] adr, dat);
      while (cmd_ready !== 1'b1) begin
         @(posedge ref_clk);
         #1;
      end
      cmd_valid = 1'b1;
      cmd_prog  = prog;
      cmd_mode  = mode;
      cmd_addr  = adr;
      cmd_data  = dat;
      @(posedge ref_clk);
      #1;
      while (cmd_ready === 1'b1) begin
         @(posedge ref_clk);
         #1;
      end
      cmd_valid = 1'b0;
   endtask : send
   task automatic read_exp(input logic [7:0] adr, input logic [7:0] exp);
      send(1'b0, 2'h0, adr, 8'h00);
      while (rsp_valid !== 1'b1) begin
         @(posedge ref_clk);
         #1;
      end
      check(rsp_data, exp, "read data");
   endtask : read_exp
   task automatic t_split();
      send(1'b1, EBAC_PM_ERASE, 8'h00, 8'h00);
      read_exp(8'h00, EBAC_ERASED);
      send(1'b1, EBAC_PM_WRITE, 8'h00, 8'h5a);
      read_exp(8'h00, 8'h5a);
      send(1'b1, EBAC_PM_WRITE, 8'h00, 8'h0f);
      read_exp(8'h00, 8'h0a);
      check(8'(bus_if.irq), 8'h01, "ready irq when idle");
   endtask : t_split
   task automatic t_atomic();
      send(1'b1, EBAC_PM_ATOMIC, 8'hff, 8'h3c);
      read_exp(8'hff, 8'h3c);
      read_exp(8'h00, 8'h0a);
   endtask : t_atomic
   // Busy time seen by the following read
   task automatic t_timing(input logic [1:0] mode, input int ticks);
      int t0;
      t0 = cycles;
      send(1'b1, mode, 8'h40, 8'hff);
      read_exp(8'h40, 8'hff);
      check(8'((cycles - t0) >= ticks * EBAC_OSC_DIV), 8'h01, "busy short");
      check(8'((cycles - t0) < ticks * EBAC_OSC_DIV + 40), 8'h01, "busy long");
   endtask : t_timing
   task automatic t_reset_mid();
      send(1'b1, EBAC_PM_ATOMIC, 8'h80, 8'h96);
      repeat (10) @(posedge ref_clk);
      #1;
      check(8'(bus_if.irq), 8'h00, "ready irq while busy");
      rst = 1'b1;
      @(posedge ref_clk);
      #1;
      rst = 1'b0;
      read_exp(8'h80, 8'h96);
   endtask : t_reset_mid
   initial begin
      repeat (8) @(posedge ref_clk);
      #1;
      rst = 1'b0;
      t_split();
      t_atomic();
      t_timing(EBAC_PM_ATOMIC, AT);
      t_timing(EBAC_PM_ERASE, ST);
      t_timing(EBAC_PM_WRITE, ST);
      t_reset_mid();
      complete_run();
   end
endmodule : eeprom_byte_access_control_test
